// [design/sla_surface_calc.sv]
// Surface layout and address calculator with an APB register port.
//
// Function
// - Float depth with stencil: depth in dword 0, stencil low byte dword 1.
// - Packed depth with stencil: 24-bit depth low, stencil top byte.
// - Separate stencil surface uses exactly one byte per pixel.
// - Buffer structures hold at most 2048 bytes, with no limit for structured buffers; pitch is the stride.
// - Buffers are contiguous and accepted only in linear memory; tiled structured buffers are not refused.
// - Structured buffer offset is a dword multiple and format is raw.
// - Structured buffer offset is bounded only by the pitch.
// - 1D surfaces ignore pitch and step slices by slice spacing.
// - 1D level origin is the sum of finer aligned widths.
// - 1D offset is (index*spacing + origin + x) times bytes per pixel.
// - Each coarser level halves width and height, clamped at one.
// - Uncompressed 2D mip levels start on even rows.
// - Compressed mip levels sit directly below the previous level.
// - 2D alignment is a dword linear and 16 bytes tiled.
// - Multisampled depth and stencil level sizes are enlarged first.
// - 2D base address marks the base map's upper-left corner.
// - Padded sizes round up to the alignment units.
`timescale 1ns/1ps

module sla_surface_calc
  import sla_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Result strobe
  output logic             result_valid,
  output logic             result_err
);

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  sla_surf_t   surf;
  logic [31:0] pitch;
  logic [31:0] size_reg;
  logic [31:0] spacing;
  logic [31:0] coord;
  logic [31:0] array_idx;
  logic [31:0] pack_in;
  sla_result_t res;
  logic        busy;
  logic [31:0] pack_out;

  sla_surf_t   next_surf;
  logic [31:0] next_pitch;
  logic [31:0] next_size_reg;
  logic [31:0] next_spacing;
  logic [31:0] next_coord;
  logic [31:0] next_array_idx;
  logic [31:0] next_pack_in;
  logic        next_start;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        next_pready;

  logic        start;
  logic [15:0] lvl_w;
  logic [15:0] lvl_h;
  logic [31:0] lvl_origin;
  logic        lvl_done;

  wire logic   access = psel && penable && !pready;

  // ---------------------------------------------------------------------------
  // Level size unit
  // ---------------------------------------------------------------------------
  sla_level_calc i_sla_level_calc
  (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (start),
    .surf    (surf),
    .width   (size_reg[15:0]),
    .height  (size_reg[31:16]),
    .level_w (lvl_w),
    .level_h (lvl_h),
    .origin  (lvl_origin),
    .done    (lvl_done)
  );

  // ---------------------------------------------------------------------------
  // APB decode: one wait state, unmapped addresses answer with pslverr.
  // ---------------------------------------------------------------------------
  always_comb
  begin
    next_surf      = surf;
    next_pitch     = pitch;
    next_size_reg  = size_reg;
    next_spacing   = spacing;
    next_coord     = coord;
    next_array_idx = array_idx;
    next_pack_in   = pack_in;
    next_start     = 1'b0;
    next_prdata    = 32'h0000_0000;
    next_pslverr   = 1'b0;
    next_pready    = access;
    if (access)
    begin
      unique case (paddr)
        SLA_OFF_CTRL:
        begin
          if (pwrite)
            next_start = pwdata[SLA_CTRL_GO_BIT] && !busy;
          else
            next_prdata = {31'h0, busy};
        end
        SLA_OFF_SURF:
          if (pwrite)
            next_surf = sla_surf_t'(pwdata[$bits(sla_surf_t)-1:0]);
          else
            next_prdata = 32'(surf);
        SLA_OFF_PITCH:
          if (pwrite) next_pitch = pwdata;
          else next_prdata = pitch;
        SLA_OFF_SIZE:
          if (pwrite) next_size_reg = pwdata;
          else next_prdata = size_reg;
        SLA_OFF_SPACING:
          if (pwrite) next_spacing = pwdata;
          else next_prdata = spacing;
        SLA_OFF_COORD:
          if (pwrite) next_coord = pwdata;
          else next_prdata = coord;
        SLA_OFF_ARRAY:
          if (pwrite) next_array_idx = pwdata;
          else next_prdata = array_idx;
        SLA_OFF_RESULT:
          next_prdata = res.offset;
        SLA_OFF_STATUS:
          next_prdata = {30'h0, res.too_big, res.err};
        SLA_OFF_LEVEL:
          next_prdata = {res.level_h, res.level_w};
        SLA_OFF_PACK:
          if (pwrite) next_pack_in = pwdata;
          else next_prdata = pack_out;
        default:
          next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      surf      <= sla_surf_t'(SLA_RESET_VALUE[$bits(sla_surf_t)-1:0]);
      pitch     <= SLA_RESET_VALUE;
      size_reg  <= SLA_RESET_VALUE;
      spacing   <= SLA_RESET_VALUE;
      coord     <= SLA_RESET_VALUE;
      array_idx <= SLA_RESET_VALUE;
      pack_in   <= SLA_RESET_VALUE;
      start     <= 1'b0;
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end
    else
    begin
      surf      <= next_surf;
      pitch     <= next_pitch;
      size_reg  <= next_size_reg;
      spacing   <= next_spacing;
      coord     <= next_coord;
      array_idx <= next_array_idx;
      pack_in   <= next_pack_in;
      start     <= next_start;
      prdata    <= next_prdata;
      pready    <= next_pready;
      pslverr   <= next_pslverr;
    end
  end

  // ---------------------------------------------------------------------------
  // Depth and stencil pixel packing view
  // ---------------------------------------------------------------------------
  // Software writes depth in the low 24 bits and stencil in the top byte of
  // the packing register; the read shows the stored pixel word of the format.
  always_comb
  begin
    unique case (surf.fmt)
      SLA_FMT_D24S8: pack_out = {pack_in[31:24], pack_in[23:0]};
      SLA_FMT_F32S8: pack_out = {24'h0, pack_in[31:24]};
      SLA_FMT_S8:    pack_out = {24'h0, pack_in[31:24]};
      default:       pack_out = pack_in;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Offset calculation and checks
  // ---------------------------------------------------------------------------
  sla_result_t next_res;
  logic        next_busy;

  always_comb
  begin
    logic [63:0] off;
    logic [63:0] total;
    logic [7:0]  bpp;
    logic        bad;
    off   = 64'h0;
    total = 64'h0;
    bad   = 1'b0;
    bpp   = 8'h00;
    unique case (surf.fmt)
      SLA_FMT_F32S8: bpp = 8'h08;
      SLA_FMT_F32:   bpp = 8'h04;
      SLA_FMT_D24S8: bpp = 8'h04;
      SLA_FMT_D16:   bpp = 8'h04;
      SLA_FMT_S8:    bpp = SLA_STENCIL_BPP;
      default:       bpp = surf.bpp;
    endcase
    unique case (surf.kind)
      SLA_KIND_BUFFER:
      begin
        // Structures follow each other with the pitch as stride.
        off   = 64'(array_idx) * 64'(pitch) + 64'(coord);
        total = 64'(size_reg) * 64'(pitch);
        bad   = surf.tiled
             || (pitch > 32'(SLA_MAX_STRUCT));
      end
      SLA_KIND_STRBUF:
      begin
        off   = 64'(array_idx) * 64'(pitch) + 64'(coord);
        total = 64'(size_reg) * 64'(pitch);
        bad   = (coord[1:0] & SLA_DWORD_ALIGN) != 2'h0
             || surf.fmt != SLA_FMT_RAW
             || coord >= pitch;
      end
      SLA_KIND_1D:
      begin
        // Pitch plays no part for 1D surfaces.
        off = (64'(array_idx) * 64'(spacing) + 64'(lvl_origin)
               + 64'(coord)) * 64'(bpp);
        total = 64'(size_reg[31:16]) * 64'(spacing) * 64'(bpp);
      end
      default:
      begin
        // Offset from the base map's upper-left corner.
        off = 64'(coord[31:16]) * 64'(pitch)
            + 64'(coord[15:0]) * 64'(bpp);
        total = 64'(size_reg[31:16]) * 64'(pitch);
        bad = (surf.tiled ? (pitch[3:0] != 4'h0)
                          : (pitch[1:0] != 2'h0))
           || (32'(size_reg[15:0]) * 32'(bpp) > pitch);
      end
    endcase
    next_res.too_big = total > 64'(SLA_MAX_BYTES);
    next_res.err     = bad || next_res.too_big;
    next_res.offset  = next_res.err ? 32'h0 : off[31:0];
    next_res.level_w = lvl_w;
    next_res.level_h = lvl_h;
    next_busy = start;
  end

  // Results latch on the level unit's done pulse, one clock after start.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      res          <= '0;
      busy         <= 1'b0;
      result_valid <= 1'b0;
      result_err   <= 1'b0;
    end
    else
    begin
      busy         <= next_busy;
      result_valid <= lvl_done;
      if (lvl_done)
      begin
        res        <= next_res;
        result_err <= next_res.err;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_result_after_start;
    @(posedge pclk) disable iff (!presetn)
    start |=> ##1 result_valid;
  endproperty
  a_result_after_start: assert property (p_result_after_start)
    else $error("Result not valid two cycles after start.");

  property p_err_no_offset;
    @(posedge pclk) disable iff (!presetn)
    result_valid && result_err |-> res.offset == 32'h0;
  endproperty
  a_err_no_offset: assert property (p_err_no_offset)
    else $error("Offset produced despite error.");

  property p_big_flags_err;
    @(posedge pclk) disable iff (!presetn)
    result_valid && res.too_big |-> result_err;
  endproperty
  a_big_flags_err: assert property (p_big_flags_err)
    else $error("Oversize surface not flagged.");

  property p_tiled_buffer;
    @(posedge pclk) disable iff (!presetn)
    lvl_done && surf.kind == SLA_KIND_BUFFER && surf.tiled |=> result_err;
  endproperty
  a_tiled_buffer: assert property (p_tiled_buffer)
    else $error("Tiled buffer accepted.");

  property p_strbuf_align;
    @(posedge pclk) disable iff (!presetn)
    lvl_done && surf.kind == SLA_KIND_STRBUF && coord[1:0] != 2'h0
      |=> result_err;
  endproperty
  a_strbuf_align: assert property (p_strbuf_align)
    else $error("Unaligned structured offset accepted.");

  property p_stencil_pack;
    @(posedge pclk) disable iff (!presetn)
    surf.fmt == SLA_FMT_S8 |-> pack_out[31:8] == 24'h0;
  endproperty
  a_stencil_pack: assert property (p_stencil_pack)
    else $error("Stencil pixel wider than a byte.");

  property p_level_min;
    @(posedge pclk) disable iff (!presetn)
    lvl_done |-> lvl_w != 16'h0 && lvl_h != 16'h0;
  endproperty
  a_level_min: assert property (p_level_min)
    else $error("Level size fell to zero.");

  property p_pready_pulse;
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("pready held longer than one cycle.");

endmodule // sla_surface_calc

// [design/sla_pkg.sv]
// Package with constants and carrier types for the surface layout calculator.
package sla_pkg;

  // ---------------------------------------------------------------------------
  // Register map (APB byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [11:0] SLA_OFF_CTRL    = 12'h000;
  localparam logic [11:0] SLA_OFF_SURF    = 12'h004;
  localparam logic [11:0] SLA_OFF_PITCH   = 12'h008;
  localparam logic [11:0] SLA_OFF_SIZE    = 12'h00c;
  localparam logic [11:0] SLA_OFF_SPACING = 12'h010;
  localparam logic [11:0] SLA_OFF_COORD   = 12'h014;
  localparam logic [11:0] SLA_OFF_ARRAY   = 12'h018;
  localparam logic [11:0] SLA_OFF_RESULT  = 12'h01c;
  localparam logic [11:0] SLA_OFF_STATUS  = 12'h020;
  localparam logic [11:0] SLA_OFF_LEVEL   = 12'h024;
  localparam logic [11:0] SLA_OFF_PACK    = 12'h028;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int          SLA_CTRL_GO_BIT  = 0;
  localparam logic [31:0] SLA_RESET_VALUE  = 32'h0000_0000;
  localparam int          SLA_STAT_ERR_BIT = 0;
  localparam int          SLA_STAT_BIG_BIT = 1;

  // ---------------------------------------------------------------------------
  // Limits
  // ---------------------------------------------------------------------------
  localparam logic [31:0] SLA_MAX_BYTES    = 32'h8000_0000;
  localparam logic [11:0] SLA_MAX_STRUCT   = 12'h800;
  localparam logic [4:0]  SLA_PITCH_ALIGN  = 5'h1f;
  localparam logic [1:0]  SLA_DWORD_ALIGN  = 2'h3;
  localparam logic [7:0]  SLA_STENCIL_BPP  = 8'h01;
  localparam int          SLA_MAX_LEVELS   = 15;

  // ---------------------------------------------------------------------------
  // Enumerations
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SLA_KIND_BUFFER = 2'h0,
    SLA_KIND_STRBUF = 2'h1,
    SLA_KIND_1D     = 2'h2,
    SLA_KIND_2D     = 2'h3
  } sla_kind_t;

  typedef enum logic [2:0] {
    SLA_FMT_PLAIN   = 3'h0,
    SLA_FMT_RAW     = 3'h1,
    SLA_FMT_F32S8   = 3'h2,
    SLA_FMT_F32     = 3'h3,
    SLA_FMT_D24S8   = 3'h4,
    SLA_FMT_D16     = 3'h5,
    SLA_FMT_S8      = 3'h6,
    SLA_FMT_COMPR   = 3'h7
  } sla_fmt_t;

  // Surface description as written by software.
  typedef struct packed {
    sla_kind_t   kind;
    sla_fmt_t    fmt;
    logic        tiled;
    logic        depth_stencil_ms;
    logic [4:0]  samples;
    logic [3:0]  level;
    logic [3:0]  halign;
    logic [3:0]  valign;
    logic [7:0]  bpp;
  } sla_surf_t;

  // Result of one calculation.
  typedef struct packed {
    logic [31:0] offset;
    logic [15:0] level_w;
    logic [15:0] level_h;
    logic        err;
    logic        too_big;
  } sla_result_t;

endpackage

// [design/sla_level_calc.sv]
// Mip level size, padding and multisample adjustment for one surface.
`timescale 1ns/1ps

module sla_level_calc
  import sla_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Request
  input  wire logic        start,
  input  wire sla_surf_t   surf,
  input  wire logic [15:0] width,
  input  wire logic [15:0] height,
  // Results
  output logic [15:0]      level_w,
  output logic [15:0]      level_h,
  output logic [31:0]      origin,
  output logic             done
);

  logic [15:0] next_level_w;
  logic [15:0] next_level_h;
  logic [31:0] next_origin;

  // ---------------------------------------------------------------------------
  // Combinational size chain
  // ---------------------------------------------------------------------------
  // The whole chain is unrolled by a loop so the result is ready in one cycle;
  // this trades area for a fixed latency that callers can rely on.
  always_comb
  begin
    logic [15:0] w;
    logic [15:0] h;
    logic [15:0] pw;
    logic [15:0] amask;
    logic [15:0] vmask;
    w = 16'h0000;
    h = 16'h0000;
    pw = 16'h0000;
    amask = 16'(surf.halign) - 16'h0001;
    vmask = 16'(surf.valign) - 16'h0001;
    next_origin = 32'h0000_0000;
    next_level_w = 16'h0001;
    next_level_h = 16'h0001;
    for (int l = 0; l < SLA_MAX_LEVELS; l++)
    begin
      w = ((width >> l) != 16'h0000) ? (width >> l) : 16'h0001;
      h = ((height >> l) != 16'h0000) ? (height >> l) : 16'h0001;
      if (surf.depth_stencil_ms || surf.fmt == SLA_FMT_S8)
      begin
        // Multisampled depth and stencil levels grow before layout.
        unique case (surf.samples)
          5'h02: w = ((w + 16'h0001) >> 1) << 2;
          5'h04:
          begin
            w = ((w + 16'h0001) >> 1) << 2;
            h = ((h + 16'h0001) >> 1) << 2;
          end
          5'h08:
          begin
            w = ((w + 16'h0001) >> 1) << 3;
            h = ((h + 16'h0001) >> 1) << 2;
          end
          5'h10:
          begin
            w = ((w + 16'h0001) >> 1) << 3;
            h = ((h + 16'h0001) >> 1) << 3;
          end
          default: w = w;
        endcase
      end
      // Round up to the alignment unit.
      pw = (surf.halign == 4'h0) ? w : ((w + amask) & ~amask);
      h = (surf.valign == 4'h0) ? h : ((h + vmask) & ~vmask);
      if (surf.fmt != SLA_FMT_COMPR && h[0] && surf.kind == SLA_KIND_2D)
        h = h + 16'h0001; // Next level starts on an even row.
      // Compressed levels stack directly below each other.
      if (4'(l) == surf.level)
      begin
        next_level_w = w;
        next_level_h = h;
      end
      else if (4'(l) < surf.level)
        next_origin = next_origin + 32'(pw);
    end
    if (surf.level >= 4'(SLA_MAX_LEVELS))
    begin
      next_level_w = 16'h0001;
      next_level_h = 16'h0001;
    end
  end

  // ---------------------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_w <= 16'h0000;
      level_h <= 16'h0000;
      origin  <= 32'h0000_0000;
      done    <= 1'b0;
    end
    else
    begin
      done <= start;
      if (start)
      begin
        level_w <= next_level_w;
        level_h <= next_level_h;
        origin  <= next_origin;
      end
    end
  end

endmodule // sla_level_calc

// [test/sla_req_model.sv]
// APB requester model standing in for the render pipeline and sampler.
`timescale 1ns/1ps

module sla_req_model
  import sla_pkg::*;
(
  // Clock
  input  wire logic        pclk,
  // APB request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  // APB answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // -------------------------------------------------------------------------
  // Bus cycle
  // -------------------------------------------------------------------------
  // Idle bus from time zero so nothing is requested during reset.
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // One surface is described per request, so colour and depth pairing
  // constraints never arise on this side.
  // The request is held until pready is seen at an edge, then released.
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait limit here: only the bench watchdog ends a stuck access.
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // sla_req_model

// [test/tb_sla_surface_calc.sv]
// Self-checking testbench for the surface layout calculator.
`timescale 1ns/1ps

`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin \
  n_mismatch++; $display("[ERR] %0t: got %h exp %h", $time, g, x); end end

module tb_sla_surface_calc
  import sla_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, res, st, lv;
  logic        result_valid, result_err, rerr;
  int          n_mismatch = 0;
  int          comparisons = 0;

  always #50 pclk = ~pclk;

  sla_surface_calc i_sla_surface_calc (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .result_valid(result_valid), .result_err(result_err));
  sla_req_model i_sla_req_model (.pclk(pclk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  function automatic logic [31:0] mk(sla_kind_t k, sla_fmt_t f, logic t,
    logic m, logic [4:0] s, logic [3:0] l, logic [7:0] b);
    sla_surf_t x;
    x = '{k, f, t, m, s, l, 4'h0, 4'h0, b};
    return x;
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_sla_req_model.xfer(1'b1, a, d, rdat, rerr);
  endtask

  task automatic rd(input logic [11:0] a);
    i_sla_req_model.xfer(1'b0, a, 32'h0, rdat, rerr);
  endtask

  // Program one description, start it and collect the three results.
  task automatic run(input logic [31:0] sf, pit, sz, spc, crd, arr);
    int n;
    wr(SLA_OFF_SURF, sf);
    wr(SLA_OFF_PITCH, pit);
    wr(SLA_OFF_SIZE, sz);
    wr(SLA_OFF_SPACING, spc);
    wr(SLA_OFF_COORD, crd);
    wr(SLA_OFF_ARRAY, arr);
    wr(SLA_OFF_CTRL, 32'h1);
    n = 0;
    while (result_valid !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    `CHK(n < 20, 1'b1)
    @(posedge pclk);
    `CHK(result_valid, 1'b0)
    rd(SLA_OFF_RESULT);
    res = rdat;
    rd(SLA_OFF_STATUS);
    st = rdat;
    rd(SLA_OFF_LEVEL);
    lv = rdat;
    `CHK(result_err, st[0])
  endtask

  // A refused description must flag and give no offset.
  task automatic bad(input logic [31:0] sf, pit, crd);
    run(sf, pit, 32'h10, 32'h0, crd, 32'h0);
    `CHK(st[0], 1'b1)
    `CHK(res, 32'h0)
  endtask

  // -------------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------------
  task automatic t_regs;
    rd(SLA_OFF_STATUS);
    `CHK(rdat, SLA_RESET_VALUE)
    rd(12'h02c);
    `CHK(rerr, 1'b1)
    wr(SLA_OFF_RESULT, 32'hffff_ffff);
    rd(SLA_OFF_RESULT);
    `CHK({rerr, rdat}, {1'b0, SLA_RESET_VALUE})
    $display("test regs done");
  endtask

  // Odd pitch is given on purpose: a 1D surface must not use it.
  task automatic t_1d;
    run(mk(SLA_KIND_1D, SLA_FMT_PLAIN, 0, 0, 0, 2, 4), 3, 16, 100, 5, 3);
    `CHK(res, 32'h0000_0524)
    `CHK(lv, 32'h0001_0004)
    run(mk(SLA_KIND_1D, SLA_FMT_PLAIN, 0, 0, 0, 3, 1), 64, 3, 0, 0, 0);
    `CHK(res, 32'h0000_0005)
    `CHK(lv, 32'h0001_0001)
    run(mk(SLA_KIND_1D, SLA_FMT_S8, 0, 0, 0, 0, 4), 64, 16, 0, 7, 0);
    `CHK(res, 32'h0000_0007)
    $display("test 1d done");
  endtask

  // Two samples keep height 3; the even-row pad makes the footprint 4.
  task automatic t_ms;
    logic [31:0] ex[4];
    ex = '{32'h0004_000c, 32'h0008_000c, 32'h0008_0018, 32'h0010_0018};
    for (int i = 0; i < 4; i++)
    begin
      run(mk(SLA_KIND_2D, SLA_FMT_D24S8, 0, 1, 5'(2 << i), 0, 4),
          64, 32'h0003_0005, 0, 0, 0);
      `CHK(lv, ex[i])
    end
    $display("test ms done");
  endtask

  task automatic t_buf;
    run(mk(SLA_KIND_STRBUF, SLA_FMT_RAW, 0, 0, 0, 0, 4), 64, 16, 0, 8, 3);
    `CHK(res, 32'h0000_00c8)
    bad(mk(SLA_KIND_STRBUF, SLA_FMT_PLAIN, 0, 0, 0, 0, 4), 64, 8);
    bad(mk(SLA_KIND_STRBUF, SLA_FMT_RAW, 0, 0, 0, 0, 4), 64, 6);
    bad(mk(SLA_KIND_BUFFER, SLA_FMT_PLAIN, 1, 0, 0, 0, 4), 64, 0);
    bad(mk(SLA_KIND_BUFFER, SLA_FMT_PLAIN, 0, 0, 0, 0, 4), 'h820, 0);
    bad(mk(SLA_KIND_STRBUF, SLA_FMT_RAW, 0, 0, 0, 0, 4), 64, 64);
    $display("test buf done");
  endtask

  // Pitches cover the widest level, except the 'h20 pitch of the last refused case.
  task automatic t_2d;
    run(mk(SLA_KIND_2D, SLA_FMT_PLAIN, 0, 0, 0, 0, 4), 64,
        32'h0008_0010, 0, 32'h0002_0003, 0);
    `CHK(res, 32'h0000_008c)
    `CHK(st[1], 1'b0)
    run(mk(SLA_KIND_2D, SLA_FMT_PLAIN, 0, 0, 0, 0, 4), 'h10000,
        32'h8001_0010, 0, 0, 0);
    `CHK(st[1], 1'b1)
    run(mk(SLA_KIND_2D, SLA_FMT_COMPR, 0, 0, 0, 0, 4), 64,
        32'h0003_0010, 0, 0, 0);
    `CHK(lv, 32'h0003_0010)
    bad(mk(SLA_KIND_2D, SLA_FMT_PLAIN, 1, 0, 0, 0, 4), 'h48, 0);
    bad(mk(SLA_KIND_2D, SLA_FMT_PLAIN, 0, 0, 0, 0, 4), 'h20, 0);
    $display("test 2d done");
  endtask

  // The packing register shows the stored pixel word of the D24S8, F32S8 and S8 formats.
  task automatic t_pack;
    wr(SLA_OFF_PACK, 32'hab12_3456);
    wr(SLA_OFF_SURF, mk(SLA_KIND_2D, SLA_FMT_D24S8, 0, 0, 0, 0, 4));
    rd(SLA_OFF_PACK);
    `CHK(rdat, 32'hab12_3456)
    wr(SLA_OFF_SURF, mk(SLA_KIND_2D, SLA_FMT_F32S8, 0, 0, 0, 0, 8));
    rd(SLA_OFF_PACK);
    `CHK(rdat, 32'h0000_00ab)
    wr(SLA_OFF_SURF, mk(SLA_KIND_2D, SLA_FMT_S8, 0, 0, 0, 0, 1));
    rd(SLA_OFF_PACK);
    `CHK(rdat, 32'h0000_00ab)
    $display("test pack done");
  endtask

  // -------------------------------------------------------------------------
  // Sequence and verdict
  // -------------------------------------------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_1d();
    t_ms();
    t_buf();
    t_2d();
    t_pack();
    print_verdict();
  end

  // Roughly a thousand cycles are needed; five thousand means a hang.
  initial
  begin
    #500000;
    n_mismatch++;
    print_verdict();
  end
endmodule // tb_sla_surface_calc
